/* File: rtl/buck_enable_softstart_control.v */
/*
 * Enable, shutdown, soft-start and current-limit retry control of a step-down regulator.
 * Assumes a serial register front end on the same clock presenting byte reads and writes,
 * a POR on srst_i, and asynchronous pins that are synchronised here.
 */
// How it works
// RULE_01: Enable pin low holds the converter in shutdown, all circuits off.
// RULE_02: Enable pin low leaves every register untouched.
// RULE_03: Register reads and writes work in shutdown while supply is above lockout.
// RULE_04: Power-on reset loads every register with its default.
// RULE_05: Bleed bit set and regulator disabled connects the output discharge load.
// RULE_06: Enable rising with selected software bit high starts soft-start.
// RULE_07: Soft-start ramps the internal reference gradually.
// RULE_08: Synchronous rectification is inhibited during soft-start.
// RULE_09: Ramp from enable to near target takes about 150 microseconds.
// RULE_10: Sixteen consecutive current-limit cycles shut down, tri-state, wait 1700 us, retry.
// RULE_11: With enable pin high the software bits turn the regulator on and off.
// RULE_12: Both software enable bits come up set after power-on reset.
// RULE_13: Light-load pulse mode can be disabled via mode bits with select pin.
// RULE_14: Seven-bit setpoint code, each step 6.25 mV.
// RULE_15: Host keeps serial transfers at or below 3.4 Mbps.
// RULE_16: Select pin chooses which software enable bit gates the output.
// RULE_17: Select pin chooses which setpoint register is active.
// RULE_18: Mode bit 0 with pin low or bit 1 with pin high forces fixed frequency.
// RULE_19: Current-limit counter clears on a normal cycle and on every restart.
// RULE_20: Losing either enable aborts soft-start or retry and returns to shutdown.
`timescale 1ns/10ps
`default_nettype none
`include "buck_ctrl_defs.vh"

module buck_enable_softstart_control
#(
    parameter SS_CYCLES    = `SOFTSTART_US * `CLK_MHZ,
    parameter RETRY_CYCLES = `RETRY_US * `CLK_MHZ
)
(
    // Clock and power-on reset
    input  wire       clk_i,
    input  wire       srst_i,
    // Pins and analog status
    input  wire       enable_pin_i,
    input  wire       voltage_select_pin_i,
    input  wire       uvlo_ok_i,
    input  wire       sw_cycle_end_i,
    input  wire       sw_cycle_climit_i,
    // Register access from the serial front end
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg_ack_o,
    // Converter control
    output reg        converter_on_o,
    output reg        switch_tristate_o,
    output reg        sync_rect_inhibit_o,
    output reg        discharge_on_o,
    output reg        forced_pwm_o,
    output reg        softstart_busy_o,
    output reg  [7:0] ref_level_o,
    output reg  [6:0] setpoint_code_o,
    output reg  [2:0] slew_code_o
);

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam [1:0] ST_OFF   = 2'd0;
    localparam [1:0] ST_SS    = 2'd1;
    localparam [1:0] ST_RUN   = 2'd2;
    localparam [1:0] ST_RETRY = 2'd3;
    localparam [23:0] SS_STEP = SS_CYCLES / `SS_STEPS;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] en_sync_r;
    reg [1:0] voltage_select_pin_sync_r;
    reg [1:0] uvlo_sync_r;
    wire      en_s   = en_sync_r[1];
    wire      voltage_select_pin_s = voltage_select_pin_sync_r[1];

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            en_sync_r   <= 2'b00;
            voltage_select_pin_sync_r <= 2'b00;
            uvlo_sync_r <= 2'b00;
        end
        else
        begin
            en_sync_r   <= {en_sync_r[0], enable_pin_i};
            voltage_select_pin_sync_r <= {voltage_select_pin_sync_r[0], voltage_select_pin_i};
            uvlo_sync_r <= {uvlo_sync_r[0], uvlo_ok_i};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0] setpoint_reg_low_r;
    reg  [7:0] setpoint_reg_high_r;
    reg  [7:0] control_register_r;
    wire       acc_ok = uvlo_sync_r[1];                                 // RULE_03
    wire       wr_ok  = reg_wr_i && acc_ok;
    wire       soft_reset = wr_ok && (reg_addr_i == `REG_CONTROL) &&
                            reg_wdata_i[`SOFT_RESET_BIT];

    // Enable pin plays no part here, so contents survive shutdown
    always @(posedge clk_i)                                             // RULE_02
    begin
        if (srst_i || soft_reset)                                       // RULE_04
        begin
            setpoint_reg_low_r  <= `SETPOINT_LOW_RST;                   // RULE_12
            setpoint_reg_high_r <= `SETPOINT_HIGH_RST;
            control_register_r  <= `CONTROL_RST;
        end
        else if (wr_ok)
        begin
            case (reg_addr_i)
                `REG_SETPOINT_LOW:  setpoint_reg_low_r  <= reg_wdata_i;
                `REG_SETPOINT_HIGH: setpoint_reg_high_r <= reg_wdata_i;
                `REG_CONTROL:       control_register_r  <= reg_wdata_i & `CONTROL_WMASK;
                default:            setpoint_reg_low_r  <= setpoint_reg_low_r;
            endcase
        end
    end

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_ack_o   <= 1'b0;
        end
        else
        begin
            reg_ack_o <= (reg_rd_i || reg_wr_i) && acc_ok;
            if (reg_rd_i && acc_ok)
            begin
                case (reg_addr_i)
                    `REG_SETPOINT_LOW:  reg_rdata_o <= setpoint_reg_low_r;
                    `REG_SETPOINT_HIGH: reg_rdata_o <= setpoint_reg_high_r;
                    `REG_CONTROL:       reg_rdata_o <= control_register_r;
                    default:            reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Enable selection
    // ----------------------------------------------------------------
    wire [7:0] active_sp = voltage_select_pin_s ? setpoint_reg_high_r : setpoint_reg_low_r; // RULE_17
    wire sw_enable_selected = active_sp[`SWEN_BIT];                     // RULE_16
    wire enabled = en_s && sw_enable_selected && acc_ok;                // RULE_11
    wire fpwm = voltage_select_pin_s ? control_register_r[`MODE_HIGH_BIT]
                       : control_register_r[`MODE_LOW_BIT];             // RULE_18

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [23:0] timer_r;
    reg [4:0]  climit_cnt_r;
    reg [7:0]  ref_r;
    wire climit_trip = sw_cycle_end_i && sw_cycle_climit_i &&
                       (climit_cnt_r == `CLIMIT_COUNT - 1);
    wire ss_done  = (ref_r == `REF_MAX);
    wire step_due = (timer_r >= SS_STEP - 1);
    wire retry_done = (timer_r >= RETRY_CYCLES - 1);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:   if (enabled) state_nxt = ST_SS;                   // RULE_06
            ST_SS:    if (climit_trip) state_nxt = ST_RETRY;
                      else if (ss_done) state_nxt = ST_RUN;
            ST_RUN:   if (climit_trip) state_nxt = ST_RETRY;            // RULE_10
            ST_RETRY: if (retry_done) state_nxt = ST_SS;
            default:  state_nxt = ST_OFF;
        endcase
        if (!enabled)
            state_nxt = ST_OFF;                                         // RULE_20
    end

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_r      <= ST_OFF;
            timer_r      <= 24'h000000;
            climit_cnt_r <= 5'h00;
            ref_r        <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                timer_r <= 24'h000000;
            else if (state_r == ST_SS && step_due)
                timer_r <= 24'h000000;
            else
                timer_r <= timer_r + 24'h000001;
            if (state_nxt == ST_SS && state_r != ST_SS)
                climit_cnt_r <= 5'h00;                                  // RULE_19
            else if (sw_cycle_end_i)
                climit_cnt_r <= sw_cycle_climit_i ? climit_cnt_r + 5'h01 : 5'h00; // RULE_19
            if (state_r == ST_OFF || state_r == ST_RETRY)
                ref_r <= 8'h00;
            else if (state_r == ST_SS && step_due && !ss_done)
                ref_r <= ref_r + 8'h01;                                 // RULE_07 RULE_09
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            converter_on_o      <= 1'b0;
            switch_tristate_o   <= 1'b1;
            sync_rect_inhibit_o <= 1'b1;
            discharge_on_o      <= 1'b0;
            forced_pwm_o        <= 1'b0;
            softstart_busy_o    <= 1'b0;
            ref_level_o         <= 8'h00;
            setpoint_code_o     <= 7'h00;
            slew_code_o         <= 3'h0;
        end
        else
        begin
            converter_on_o      <= (state_nxt == ST_SS) || (state_nxt == ST_RUN); // RULE_01
            switch_tristate_o   <= (state_nxt == ST_OFF) || (state_nxt == ST_RETRY); // RULE_10
            sync_rect_inhibit_o <= (state_nxt != ST_RUN);               // RULE_08
            discharge_on_o      <= control_register_r[`DISCH_BIT] && !enabled; // RULE_05
            forced_pwm_o        <= fpwm;                                // RULE_13
            softstart_busy_o    <= (state_nxt == ST_SS);
            ref_level_o         <= ref_r;
            setpoint_code_o     <= active_sp[6:0];                      // RULE_14
            slew_code_o         <= control_register_r[6:4];
        end
    end

endmodule
`default_nettype wire

/* File: rtl/buck_ctrl_defs.vh */
/*
 * Constants for the enable, soft-start and retry control of the step-down regulator.
 * Assumes a 100 MHz core clock and byte-wide register access.
 */
`ifndef BUCK_CTRL_DEFS_VH
`define BUCK_CTRL_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_SETPOINT_LOW   8'h00
`define REG_SETPOINT_HIGH  8'h01
`define REG_CONTROL        8'h02

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define SETPOINT_LOW_RST   8'hc8
`define SETPOINT_HIGH_RST  8'hc8
`define CONTROL_RST        8'h82
`define SWEN_BIT           7
`define DISCH_BIT          7
`define SOFT_RESET_BIT     2
`define MODE_LOW_BIT       0
`define MODE_HIGH_BIT      1
`define CONTROL_WMASK      8'hf3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ            100
`define SOFTSTART_US       150
`define RETRY_US           1700
`define CLIMIT_COUNT       16
`define SS_STEPS           256
`define REF_MAX            8'hff

`endif

/* File: tb/buck_ctrl_asserts.sv */
/* Checker for the enable and soft-start control.
   Sees only the top ports; assumes a POR on srst_i. */
`timescale 1ns/10ps
`default_nettype none
module buck_ctrl_checker
(
    // Clock, reset and inputs
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic       enable_pin_i,
    input wire logic       uvlo_ok_i,
    input wire logic       sw_cycle_end_i,
    input wire logic       sw_cycle_climit_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    // Outputs
    input wire logic       reg_ack_o,
    input wire logic       converter_on_o,
    input wire logic       switch_tristate_o,
    input wire logic       sync_rect_inhibit_o,
    input wire logic       discharge_on_o,
    input wire logic       softstart_busy_o,
    input wire logic [7:0] ref_level_o
);
    logic [4:0] climit_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Run of current-limited cycle ends while the converter is on
    always_ff @(posedge clk_i)
        if (srst_i || !converter_on_o || (sw_cycle_end_i && !sw_cycle_climit_i))
            climit_r <= 5'h00;
        else if (sw_cycle_end_i)
            climit_r <= climit_r + 5'h01;
    access_ack_a: assert property ((reg_rd_i || reg_wr_i) && $past(uvlo_ok_i, 2) &&
        !$past(srst_i) && !$past(srst_i, 2) |=> reg_ack_o) else $error("access not acknowledged");
    off_pin_low_a: assert property (!enable_pin_i [*4] |-> !converter_on_o)
        else $error("converter on with enable pin low");
    rect_inhibit_a: assert property (softstart_busy_o |-> sync_rect_inhibit_o)
        else $error("rectifier not inhibited in soft-start");
    ramp_gradual_a: assert property (softstart_busy_o && $past(softstart_busy_o) |->
        ref_level_o == $past(ref_level_o) || ref_level_o == $past(ref_level_o) + 8'h01)
        else $error("reference stepped during soft-start");
    busy_on_a: assert property (softstart_busy_o |-> converter_on_o)
        else $error("soft-start without converter on");
    bleed_off_a: assert property (discharge_on_o |-> !converter_on_o)
        else $error("discharge load while converter on");
    tristate_off_a: assert property (converter_on_o |-> !switch_tristate_o)
        else $error("switch tri-stated while on");
    climit_trip_a: assert property (sw_cycle_end_i && sw_cycle_climit_i &&
        climit_r == 5'h0f && converter_on_o |-> ##[1:3] !converter_on_o)
        else $error("no shutdown after sixteen limited cycles");
    cover property (softstart_busy_o ##1 !softstart_busy_o && converter_on_o);
    cover property (converter_on_o ##1 switch_tristate_o && enable_pin_i);
    cover property (discharge_on_o);
endmodule
bind buck_enable_softstart_control buck_ctrl_checker i_buck_ctrl_checker (.clk_i, .srst_i,
    .enable_pin_i, .uvlo_ok_i, .sw_cycle_end_i, .sw_cycle_climit_i, .reg_wr_i, .reg_rd_i,
    .reg_ack_o, .converter_on_o, .switch_tristate_o, .sync_rect_inhibit_o, .discharge_on_o,
    .softstart_busy_o, .ref_level_o);
`default_nettype wire

/* File: tb/host_model.sv */
/* Host model: drives pins, supply status, cycle events and byte strobes.
   Changes everything on the falling clock edge only. */
`timescale 1ns/10ps
`default_nettype none
module host_model
(
    // Clock and device answers
    input  wire logic       clk_i,
    input  wire logic       reg_ack_i,
    input  wire logic [7:0] reg_rdata_i,
    // Pins, status and strobes
    output var  logic       enable_pin_o = 1'b0,
    output var  logic       voltage_select_pin_o = 1'b0,
    output var  logic       uvlo_ok_o = 1'b1,
    output var  logic       sw_cycle_end_o = 1'b0,
    output var  logic       sw_cycle_climit_o = 1'b0,
    output var  logic       reg_wr_o = 1'b0,
    output var  logic       reg_rd_o = 1'b0,
    output var  logic [7:0] reg_addr_o = 8'h00,
    output var  logic [7:0] reg_wdata_o = 8'h00
);
    // A byte takes nine bit times at 3.4 Mbps, about 265 clocks
    localparam int BYTE_GAP = 270;
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic ack);
        @(negedge clk_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = {a, wd, wr, !wr};
        @(negedge clk_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = {~a, ~wd, 2'b00};
        {rd, ack} = {reg_rdata_i, reg_ack_i};
        repeat (BYTE_GAP) @(negedge clk_i);
    endtask
    task automatic pins(input logic en, input logic vs, input logic uv);
        @(negedge clk_i);
        {enable_pin_o, voltage_select_pin_o, uvlo_ok_o} = {en, vs, uv};
        repeat (4) @(negedge clk_i);
    endtask
    task automatic pulses(input int n, input logic hit);
        repeat (n)
        begin
            @(negedge clk_i);
            {sw_cycle_end_o, sw_cycle_climit_o} = {1'b1, hit};
            @(negedge clk_i);
            {sw_cycle_end_o, sw_cycle_climit_o} = {1'b0, !hit};
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/* Top testbench: owns clock and reset; the host model drives the rest.
   Soft-start and retry counts are shortened to 512 and 50 cycles. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    wire logic en, vs, uv, cend, chit, wr, rd, ack, conv, tri_st, inh, dis, fpwm, busy;
    wire logic [7:0] addr, wdata, rdata, ref_lvl;
    wire logic [6:0] setp;
    wire logic [2:0] slew;
    wire logic [7:0] st = {2'b00, fpwm, busy, dis, inh, tri_st, conv};
    int n_errors = 0;
    int checked = 0;
    int m;
    logic [7:0] d;
    logic k;
    always #5 clk_i = ~clk_i;
    buck_enable_softstart_control #(.SS_CYCLES(512), .RETRY_CYCLES(50))
        i_buck_enable_softstart_control (.clk_i(clk_i), .srst_i(srst_i), .enable_pin_i(en),
        .voltage_select_pin_i(vs), .uvlo_ok_i(uv), .sw_cycle_end_i(cend),
        .sw_cycle_climit_i(chit), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .converter_on_o(conv),
        .switch_tristate_o(tri_st), .sync_rect_inhibit_o(inh), .discharge_on_o(dis),
        .forced_pwm_o(fpwm), .softstart_busy_o(busy), .ref_level_o(ref_lvl),
        .setpoint_code_o(setp), .slew_code_o(slew));
    host_model i_host_model (.clk_i(clk_i), .reg_ack_i(ack), .reg_rdata_i(rdata),
        .enable_pin_o(en), .voltage_select_pin_o(vs), .uvlo_ok_o(uv), .sw_cycle_end_o(cend),
        .sw_cycle_climit_o(chit), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        i_host_model.access(1'b0, a, 8'h00, d, k);
        chk({7'h00, k}, 8'h01);
        chk(d, exp);
    endtask
    task automatic wc(input logic [7:0] a, input logic [7:0] v);
        i_host_model.access(1'b1, a, v, d, k);
        chk({7'h00, k}, 8'h01);
    endtask
    task automatic wait_st(input logic [7:0] exp, input int lim);
        for (int i = 0; i < lim && st !== exp; i++)
            @(negedge clk_i);
        chk(st, exp);
    endtask
    task automatic final_report;
        $display("checks %0d, wrong values %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        rc(8'h00, 8'hc8);
        rc(8'h01, 8'hc8);
        rc(8'h02, 8'h82);
        rc(8'h07, 8'h00);
        chk(st, 8'h0e);
        wc(8'h00, 8'hd0);
        wc(8'h01, 8'ha5);
        rc(8'h00, 8'hd0);
        chk({1'b0, setp}, 8'h50);
        for (m = 0; m < 8; m++)
        begin
            wc(8'h02, {4'hd, 2'b10, m[1:0]});
            i_host_model.pins(1'b0, m[2], 1'b1);
            rc(8'h02, {4'hd, 2'b00, m[1:0]});
            chk(st, {2'b00, m[2] ? m[1] : m[0], 5'h0e});
        end
        chk({1'b0, setp}, 8'h25);
        chk({5'h00, slew}, 8'h05);
        $display("test shutdown registers done");
        wc(8'h02, 8'h80);
        i_host_model.pins(1'b1, 1'b0, 1'b1);
        wait_st(8'h15, 10);
        wait_st(8'h01, 700);
        chk(ref_lvl, 8'hff);
        wc(8'h00, 8'h50);
        wait_st(8'h0e, 10);
        i_host_model.pins(1'b1, 1'b1, 1'b1);
        wait_st(8'h15, 10);
        i_host_model.pins(1'b0, 1'b1, 1'b1);
        wait_st(8'h0e, 10);
        i_host_model.pins(1'b1, 1'b1, 1'b1);
        wait_st(8'h01, 700);
        $display("test enable and soft-start done");
        i_host_model.pulses(15, 1'b1);
        i_host_model.pulses(1, 1'b0);
        i_host_model.pulses(15, 1'b1);
        chk(st, 8'h01);
        i_host_model.pulses(1, 1'b1);
        wait_st(8'h06, 5);
        repeat (40) @(negedge clk_i);
        chk(st, 8'h06);
        wait_st(8'h15, 30);
        i_host_model.pulses(15, 1'b1);
        chk(st, 8'h15);
        i_host_model.pulses(1, 1'b1);
        wait_st(8'h06, 5);
        $display("test current limit retry done");
        wc(8'h02, 8'h04);
        rc(8'h01, 8'hc8);
        rc(8'h02, 8'h82);
        $display("test soft reset done");
        i_host_model.pins(1'b1, 1'b1, 1'b0);
        i_host_model.access(1'b0, 8'h02, 8'h00, d, k);
        chk({7'h00, k}, 8'h00);
        $display("test supply lockout done");
        final_report();
    end
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
